// ==== src/hra_attr_byte.sv ====
// Purpose: Next value of one register byte under per-bit access attributes.
// Assumes: Masks are disjoint; bits in no mask are read-only.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module hra_attr_byte #(
    parameter int W = 8
) (
    input wire logic [W-1:0] cur_i,
    input wire logic [W-1:0] wdata_i,
    input wire logic we_i,
    input wire logic [W-1:0] rw_i,
    input wire logic [W-1:0] wc_i,
    input wire logic [W-1:0] wo_i,
    input wire logic [W-1:0] lk_i,
    input wire logic locked_i,
    input wire logic wo_done_i,
    input wire logic [W-1:0] hw_set_i,
    output logic [W-1:0] next_o
);
    logic [W-1:0] wr_ok;
    logic [W-1:0] wrote;
    logic [W-1:0] cleared;

    always_comb begin
        wr_ok = rw_i | (lk_i & ~{W{locked_i}}) | (wo_i & ~{W{wo_done_i}}); // R6 R7 R8 R10
        wrote = we_i ? ((cur_i & ~wr_ok) | (wdata_i & wr_ok)) : cur_i; // R5 R20
        cleared = we_i ? (wrote & ~(wc_i & wdata_i)) : wrote; // R9
        // Hardware set outranks a clear in the same cycle so no event is lost
        next_o = cleared | (hw_set_i & wc_i);
    end
endmodule

// ==== src/hra_defines.svh ====
// Purpose: Constants for the host register access bank: I/O ports, layout, attributes, defaults.
// Assumes: Host I/O cycles arrive dword aligned with byte enables.
// Notes: Attribute masks mark the bits of each register; unmarked bits are read-only.
//
// Contract
// R1 - Registers reached from host I/O space through config address and data ports.
// R2 - Byte, word and dword accesses touch or return only the enabled bytes.
// R3 - Config address register takes full dword accesses only; narrower ones are refused.
// R4 - Lowest byte address carries the least significant byte of every field.
// R5 - Read-only bits ignore host writes.
// R6 - Read/write bits store the written value and return it on reads.
// R7 - Lockable registers are readable and writable until locked.
// R8 - Lockable bits turn read-only once the lock bit is set.
// R9 - Writing one clears a clearable bit; writing zero leaves it alone.
// R10 - Write-once bits take only the first write after reset, then read-only.
// R11 - Host masks off reserved bits on reads.
// R12 - Host read-merge-writes registers holding reserved bits.
// R13 - Host may write the config address register directly.
// R14 - Reserved locations read an undefined value.
// R15 - Host never writes reserved locations.
// R16 - Full reset loads every register with its default.
// R17 - Some defaults come from strap pins sampled at reset.
// R18 - Initialisation software programs registers after reset.
// R19 - Config data cycles run only while config address bit 31 is set.
// R20 - Writes apply each bit attribute independently within the enabled bytes.
`ifndef HRA_DEFINES_SVH
`define HRA_DEFINES_SVH

`define HRA_IO_CA_DW 14'h033e
`define HRA_IO_CD_DW 14'h033f
`define HRA_BE_FULL 4'hf
`define HRA_ALL_ONES 32'hffff_ffff
`define HRA_CA_WMASK 32'h80ff_fffc
`define HRA_CA_EN_BIT 31
`define HRA_NUM_REGS 16
`define HRA_STRAP_W 8
`define HRA_STATUS_W 8
`define HRA_LFSR_SEED 16'hace1
`define HRA_LFSR_TAPS 16'hb400

`define HRA_IDX_ID 4'h0
`define HRA_IDX_CTRL 4'h1
`define HRA_IDX_STATUS 4'h2
`define HRA_IDX_LOCKCFG 4'h3
`define HRA_IDX_ONCE 4'h4
`define HRA_IDX_STRAP 4'h5
`define HRA_IDX_FIRST_RSVD 4'h6
`define HRA_LOCK_BIT 8

// Identity value is arbitrary
`define HRA_ID_VALUE 32'h0000_a5a5
`define HRA_CTRL_DFLT 32'h0000_0001
`define HRA_CTRL_RW 32'h0000_ffff
`define HRA_STATUS_WC 32'h0000_00ff
`define HRA_LOCKCFG_LK 32'h0000_ffff
`define HRA_ONCE_WO 32'h0000_01ff
`define HRA_STRAP_RW 32'h0000_00ff
`define HRA_ZERO 32'h0000_0000

`endif

// ==== src/hra_pkg.sv ====
// Purpose: Types shared by the host register access bank.
// Assumes: Constants come from hra_defines.svh.
// Notes: Carriers for host I/O request and response.
`include "hra_defines.svh"
package hra_pkg;
    typedef struct packed {
        logic valid;
        logic wr;
        logic [15:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } hra_io_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
    } hra_io_rsp_t;

    typedef struct packed {
        logic [31:0] rw;
        logic [31:0] wc;
        logic [31:0] wo;
        logic [31:0] lk;
        logic [31:0] dflt;
    } hra_attr_t;
endpackage

// ==== src/hra_regbank.sv ====
// Purpose: Host register bank reached through the config address and data I/O ports.
// Assumes: One request per cycle at most; answer one cycle later; strap pins are asynchronous.
// Notes: Narrow config address or misdirected accesses read all ones in the enabled bytes and write nothing.
`timescale 1ns/1ps
`include "hra_defines.svh"
module hra_regbank (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input hra_pkg::hra_io_req_t io_req_i,
    input wire logic [`HRA_STRAP_W-1:0] strap_i,
    input wire logic [`HRA_STATUS_W-1:0] status_set_i,
    output hra_pkg::hra_io_rsp_t io_rsp_o,
    output logic [31:0] cfg_addr_o,
    output logic [15:0] ctrl_o,
    output logic [15:0] lockcfg_o,
    output logic [7:0] once_o,
    output logic lock_o,
    output logic [7:0] strap_cfg_o
);
    import hra_pkg::*;

    function automatic hra_attr_t reg_attr(input logic [3:0] idx);
        hra_attr_t a;
        a = '0;
        case (idx)
            `HRA_IDX_ID: begin
                a.dflt = `HRA_ID_VALUE;
            end
            `HRA_IDX_CTRL: begin
                a.rw = `HRA_CTRL_RW;
                a.dflt = `HRA_CTRL_DFLT;
            end
            `HRA_IDX_STATUS: begin
                a.wc = `HRA_STATUS_WC;
            end
            `HRA_IDX_LOCKCFG: begin
                a.lk = `HRA_LOCKCFG_LK;
            end
            `HRA_IDX_ONCE: begin
                a.wo = `HRA_ONCE_WO;
            end
            `HRA_IDX_STRAP: begin
                a.rw = `HRA_STRAP_RW;
            end
            default: begin
                a = '0;
            end
        endcase
        return a;
    endfunction

    logic [31:0] mem [`HRA_NUM_REGS];
    logic [31:0] next_mem [`HRA_NUM_REGS];
    logic [31:0] byte_next [`HRA_NUM_REGS];
    logic [31:0] hw_set [`HRA_NUM_REGS];
    hra_attr_t attr [`HRA_NUM_REGS];
    logic [3:0] wo_done [`HRA_NUM_REGS];
    logic [3:0] next_wo_done [`HRA_NUM_REGS];
    logic [31:0] cfg_addr;
    logic [31:0] next_cfg_addr;
    hra_io_rsp_t rsp;
    hra_io_rsp_t next_rsp;
    logic [15:0] lfsr;
    logic [15:0] next_lfsr;
    logic [`HRA_STRAP_W-1:0] strap_meta;
    logic [`HRA_STRAP_W-1:0] strap_sync;
    logic strap_pend;
    logic next_strap_pend;

    logic hit_ca;
    logic hit_cd;
    logic full_dw;
    logic cfg_sel;
    logic [3:0] idx;
    logic idx_rsvd;
    logic data_wr;
    logic ca_wr;
    logic locked;
    logic [31:0] be_mask;

    // Decode of the host cycle
    always_comb begin
        hit_ca = io_req_i.valid && (io_req_i.addr[15:2] == `HRA_IO_CA_DW); // R1
        hit_cd = io_req_i.valid && (io_req_i.addr[15:2] == `HRA_IO_CD_DW); // R1
        full_dw = (io_req_i.be == `HRA_BE_FULL);
        // Only bus 0, device 0, function 0 and the low register window belong here
        cfg_sel = cfg_addr[`HRA_CA_EN_BIT] && (cfg_addr[23:8] == 16'h0000) && (cfg_addr[7:6] == 2'h0); // R19
        idx = cfg_addr[5:2];
        idx_rsvd = (idx >= `HRA_IDX_FIRST_RSVD);
        // Reserved locations never take a write; a stray one cannot upset state
        data_wr = hit_cd && io_req_i.wr && cfg_sel && !idx_rsvd; // R19
        ca_wr = hit_ca && io_req_i.wr && full_dw; // R3
        locked = mem[`HRA_IDX_ONCE][`HRA_LOCK_BIT]; // R8
        // Byte lane n is address offset n, least significant first
        be_mask = {{8{io_req_i.be[3]}}, {8{io_req_i.be[2]}}, {8{io_req_i.be[1]}}, {8{io_req_i.be[0]}}}; // R4
    end

    always_comb begin
        for (int r = 0; r < `HRA_NUM_REGS; r++) begin
            hw_set[r] = `HRA_ZERO;
        end
        hw_set[`HRA_IDX_STATUS] = {24'h000000, status_set_i}; // R9
    end

    genvar gr;
    genvar gb;
    generate
        for (gr = 0; gr < `HRA_NUM_REGS; gr++) begin : g_reg
            assign attr[gr] = reg_attr(4'(gr));
            for (gb = 0; gb < 4; gb++) begin : g_byte
                hra_attr_byte #(
                    .W(8)
                ) u_byte (
                    .cur_i(mem[gr][8*gb +: 8]),
                    .wdata_i(io_req_i.wdata[8*gb +: 8]),
                    .we_i(data_wr && (idx == 4'(gr)) && io_req_i.be[gb]), // R2 R20
                    .rw_i(attr[gr].rw[8*gb +: 8]),
                    .wc_i(attr[gr].wc[8*gb +: 8]),
                    .wo_i(attr[gr].wo[8*gb +: 8]),
                    .lk_i(attr[gr].lk[8*gb +: 8]),
                    .locked_i(locked),
                    .wo_done_i(wo_done[gr][gb]),
                    .hw_set_i(hw_set[gr][8*gb +: 8]),
                    .next_o(byte_next[gr][8*gb +: 8])
                );
            end
        end
    endgenerate

    // Register array, write-once tracking and strap capture
    always_comb begin
        for (int r = 0; r < `HRA_NUM_REGS; r++) begin
            next_mem[r] = byte_next[r];
            next_wo_done[r] = wo_done[r];
            if (data_wr && (idx == 4'(r))) begin
                next_wo_done[r] = wo_done[r] | io_req_i.be; // R10
            end
        end
        // Straps are taken on the first cycle after release, never inside reset
        if (strap_pend) begin
            next_mem[`HRA_IDX_STRAP][`HRA_STRAP_W-1:0] = strap_sync; // R17
        end
        next_strap_pend = rst_i;
        if (rst_i) begin
            for (int r = 0; r < `HRA_NUM_REGS; r++) begin
                next_mem[r] = attr[r].dflt; // R16
                next_wo_done[r] = 4'h0;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        for (int r = 0; r < `HRA_NUM_REGS; r++) begin
            mem[r] <= next_mem[r];
            wo_done[r] <= next_wo_done[r];
        end
        strap_pend <= next_strap_pend;
    end

    // Two-flop synchroniser for the strap pins
    always_ff @(posedge clk_sys_i) begin
        strap_meta <= strap_i;
        strap_sync <= strap_meta;
    end

    // Config address register and host answer
    always_comb begin
        next_cfg_addr = cfg_addr;
        if (ca_wr) begin
            next_cfg_addr = io_req_i.wdata & `HRA_CA_WMASK; // R3 R6
        end
        next_lfsr = lfsr[0] ? ((lfsr >> 1) ^ `HRA_LFSR_TAPS) : (lfsr >> 1);
        next_rsp.ack = io_req_i.valid; // R1
        next_rsp.rdata = `HRA_ALL_ONES;
        if (hit_ca) begin
            next_rsp.rdata = full_dw ? cfg_addr : `HRA_ALL_ONES; // R3
        end else if (hit_cd && cfg_sel) begin
            // Reserved reads return a running pseudo-random pattern
            next_rsp.rdata = idx_rsvd ? {lfsr, lfsr} : mem[idx]; // R14
        end
        next_rsp.rdata = next_rsp.rdata & be_mask; // R2 R4
        if (rst_i) begin
            next_cfg_addr = `HRA_ZERO; // R16
            next_lfsr = `HRA_LFSR_SEED;
            next_rsp = '0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        cfg_addr <= next_cfg_addr;
        lfsr <= next_lfsr;
        rsp <= next_rsp;
    end

    assign io_rsp_o = rsp;
    assign cfg_addr_o = cfg_addr;
    assign ctrl_o = mem[`HRA_IDX_CTRL][15:0];
    assign lockcfg_o = mem[`HRA_IDX_LOCKCFG][15:0];
    assign once_o = mem[`HRA_IDX_ONCE][7:0];
    assign lock_o = locked;
    assign strap_cfg_o = mem[`HRA_IDX_STRAP][`HRA_STRAP_W-1:0];

    // Checks
    AST_ACK_NEXT: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R1
        io_req_i.valid |=> rsp.ack)
        else $error("host request not answered next cycle");

    AST_CA_NARROW: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R3
        (hit_ca && io_req_i.wr && !full_dw) |=> $stable(cfg_addr))
        else $error("narrow write changed config address");

    AST_CA_FULL: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R6
        ca_wr |=> (cfg_addr == ($past(io_req_i.wdata) & `HRA_CA_WMASK)))
        else $error("config address did not store dword write");

    AST_ID_RO: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R5
        (data_wr && idx == `HRA_IDX_ID) |=> (mem[`HRA_IDX_ID] == `HRA_ID_VALUE))
        else $error("read-only register changed");

    AST_BYTE_LANE: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R20
        (data_wr && idx == `HRA_IDX_CTRL && io_req_i.be == 4'h1)
        |=> (mem[`HRA_IDX_CTRL][15:8] == $past(mem[`HRA_IDX_CTRL][15:8]))
            && (mem[`HRA_IDX_CTRL][7:0] == $past(io_req_i.wdata[7:0])))
        else $error("byte write touched a disabled lane");

    AST_WC_CLEAR: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R9
        (data_wr && idx == `HRA_IDX_STATUS && io_req_i.be[0] && status_set_i == 8'h00)
        |=> (mem[`HRA_IDX_STATUS][7:0] == ($past(mem[`HRA_IDX_STATUS][7:0]) & ~$past(io_req_i.wdata[7:0]))))
        else $error("clearable bits wrong after write");

    AST_WC_SET_WINS: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R9
        (status_set_i != 8'h00) |=> ((mem[`HRA_IDX_STATUS][7:0] & $past(status_set_i)) == $past(status_set_i)))
        else $error("hardware event lost");

    AST_LOCKED: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R8
        (locked && data_wr && idx == `HRA_IDX_LOCKCFG) |=> $stable(mem[`HRA_IDX_LOCKCFG]))
        else $error("locked register changed");

    AST_WO_ONCE: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R10
        (wo_done[`HRA_IDX_ONCE][0] && data_wr && idx == `HRA_IDX_ONCE) |=> (once_o == $past(once_o)))
        else $error("write-once bits took a second write");

    AST_DISABLED_ONES: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R19
        (hit_cd && !cfg_addr[`HRA_CA_EN_BIT] && io_req_i.be == `HRA_BE_FULL) |=> (rsp.rdata == `HRA_ALL_ONES))
        else $error("disabled config cycle returned data");

    AST_STRAP_LOAD: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R17
        $fell(rst_i) |=> (strap_cfg_o == $past(strap_sync)))
        else $error("strap default not captured after reset");

    AST_RESET_DFLT: assert property (@(posedge clk_sys_i) // R16
        // Checked on the first edge out of reset; the registers hold no value before the first reset edge
        $fell(rst_i) |-> (ctrl_o == `HRA_CTRL_DFLT) && (cfg_addr == `HRA_ZERO) && !rsp.ack)
        else $error("reset defaults not loaded");
endmodule

// ==== tb/host_register_access_attributes_tb_top.sv ====
// Purpose: Self-checking bench for the host register bank.
// Assumes: Host model drives one request every other cycle.
// Notes: Expected values come from bench functions, never from the bank.
`timescale 1ns/1ps
`include "hra_defines.svh"
module host_register_access_attributes_tb_top;
    import hra_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] strap = 8'h00;
    logic [7:0] status_set = 8'h00;
    hra_io_req_t io_req;
    hra_io_rsp_t io_rsp;
    logic [31:0] cfg_addr, rd, wd, exp_ctrl;
    logic [15:0] ctrl, lockcfg;
    logic [7:0] once, strap_cfg;
    logic [3:0] be;
    logic lock, ack;
    int n_fail = 0;
    int n_tests = 0;
    integer seed = 32'hcc31;

    always #25 clk_sys_i = ~clk_sys_i;

    hra_regbank DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .io_req_i(io_req), .strap_i(strap),
        .status_set_i(status_set), .io_rsp_o(io_rsp), .cfg_addr_o(cfg_addr), .ctrl_o(ctrl),
        .lockcfg_o(lockcfg), .once_o(once), .lock_o(lock), .strap_cfg_o(strap_cfg));
    hra_host_model host (.clk_sys_i(clk_sys_i), .io_rsp_i(io_rsp), .io_req_o(io_req));

    function automatic logic [31:0] lanes(input logic [3:0] b);
        logic [31:0] m;
        for (int i = 0; i < 4; i++) begin
            m[8*i +: 8] = {8{b[i]}};
        end
        return m;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] cur, input logic [31:0] d, input logic [3:0] b,
                                          input logic [31:0] msk);
        return (cur & ~(lanes(b) & msk)) | (d & lanes(b) & msk);
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic io(input logic wr, input logic [15:0] a, input logic [3:0] b, input logic [31:0] d);
        host.cyc(wr, a, b, d, rd, ack);
        check({31'h0, ack}, 32'h1);
    endtask

    task automatic sel(input logic [3:0] idx);
        io(1'b1, 16'h0cf8, `HRA_BE_FULL, {24'h80_0000, 2'b00, idx, 2'b00});
    endtask

    task automatic do_reset(input logic [7:0] s);
        @(posedge clk_sys_i);
        #1;
        rst_i = 1'b1;
        strap = s;
        repeat (8) @(posedge clk_sys_i);
        #1;
        rst_i = 1'b0;
        repeat (2) @(posedge clk_sys_i);
        #1;
        check(cfg_addr, `HRA_ZERO);
        check({16'h0, ctrl}, `HRA_CTRL_DFLT);
        check({lockcfg, 7'h0, lock, once}, `HRA_ZERO);
        check({24'h0, strap_cfg}, {24'h0, s});
    endtask

    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        #(50 * 4000);
        n_fail++;
        close_out();
    end

    initial begin
        do_reset(8'h5a);
        io(1'b0, 16'h0cfc, 4'hf, 32'h0);
        check(rd, `HRA_ALL_ONES);
        io(1'b1, 16'h0cfc, 4'hf, 32'h0000_ffff);
        check({16'h0, ctrl}, `HRA_CTRL_DFLT);
        // Deliberately narrow config address cycles
        io(1'b1, 16'h0cf8, 4'h3, 32'h8000_0004);
        check(cfg_addr, `HRA_ZERO);
        io(1'b0, 16'h0cf8, 4'h3, 32'h0);
        check(rd, 32'h0000_ffff);
        io(1'b1, 16'h0cf8, 4'hf, `HRA_ALL_ONES);
        check(cfg_addr, `HRA_CA_WMASK);
        sel(`HRA_IDX_ID);
        io(1'b1, 16'h0cfc, 4'hf, 32'h1234_5678);
        io(1'b0, 16'h0cfc, 4'hf, 32'h0);
        check(rd, `HRA_ID_VALUE);
        sel(`HRA_IDX_CTRL);
        exp_ctrl = `HRA_CTRL_DFLT;
        for (int i = 0; i < 40; i++) begin
            wd = $random(seed);
            be = (i == 0) ? 4'h2 : wd[27:24];
            io(1'b1, 16'h0cfc, be, wd);
            exp_ctrl = merge(exp_ctrl, wd, be, `HRA_CTRL_RW);
            check({16'h0, ctrl}, exp_ctrl);
            wd = $random(seed);
            io(1'b0, 16'h0cfc, wd[3:0], 32'h0);
            check(rd, exp_ctrl & lanes(wd[3:0]));
        end
        io(1'b1, 16'h0cfc, 4'h3, 32'h0000_beef);
        check({16'h0, ctrl}, 32'h0000_beef);
        // Upper half of the control register is reserved: read, merge the defined bits, write back
        io(1'b0, 16'h0cfc, 4'hf, 32'h0);
        io(1'b1, 16'h0cfc, 4'hf, (rd & 32'hffff_00ff) | 32'h0000_1200);
        check({16'h0, ctrl}, 32'h0000_12ef);
        sel(`HRA_IDX_STATUS);
        @(posedge clk_sys_i);
        #1;
        status_set = 8'ha5;
        @(posedge clk_sys_i);
        #1;
        status_set = 8'h00;
        io(1'b1, 16'h0cfc, 4'h1, 32'h0000_0005);
        io(1'b1, 16'h0cfc, 4'h0, 32'h0000_00ff);
        io(1'b1, 16'h0cfc, 4'h1, 32'h0000_0000);
        io(1'b0, 16'h0cfc, 4'hf, 32'h0);
        check(rd, 32'h0000_00a0);
        // Hardware set and a write-one clear of the same bit meet at one edge: the set must win
        fork
            io(1'b1, 16'h0cfc, 4'h1, 32'h0000_0080);
            begin
                @(posedge clk_sys_i);
                #1;
                status_set = 8'h80;
                @(posedge clk_sys_i);
                #1;
                status_set = 8'h00;
            end
        join
        io(1'b0, 16'h0cfc, 4'hf, 32'h0);
        check(rd, 32'h0000_00a0);
        sel(`HRA_IDX_LOCKCFG);
        io(1'b1, 16'h0cfc, 4'hf, 32'hffff_1234);
        io(1'b0, 16'h0cfc, 4'hf, 32'h0);
        check(rd, 32'h0000_1234);
        sel(`HRA_IDX_ONCE);
        io(1'b1, 16'h0cfc, 4'h1, 32'h0000_003c);
        io(1'b1, 16'h0cfc, 4'h1, 32'h0000_00ff);
        check({24'h0, once}, 32'h0000_003c);
        io(1'b1, 16'h0cfc, 4'h2, 32'h0000_0100);
        check({31'h0, lock}, 32'h1);
        sel(`HRA_IDX_LOCKCFG);
        io(1'b1, 16'h0cfc, 4'hf, 32'h0000_ffff);
        check({16'h0, lockcfg}, 32'h0000_1234);
        sel(`HRA_IDX_STRAP);
        io(1'b1, 16'h0cfc, 4'h1, 32'h0000_0077);
        check({24'h0, strap_cfg}, 32'h0000_0077);
        // Reserved place is only read; its value is undefined
        sel(`HRA_IDX_FIRST_RSVD);
        io(1'b0, 16'h0cfc, 4'hf, 32'h0);
        io(1'b0, 16'h0080, 4'h6, 32'h0);
        check(rd, 32'h00ff_ff00);
        do_reset(8'hc3);
        sel(`HRA_IDX_ONCE);
        io(1'b1, 16'h0cfc, 4'h1, 32'h0000_0099);
        check({24'h0, once}, 32'h0000_0099);
        close_out();
    end
endmodule

// ==== tb/hra_host_model.sv ====
// Purpose: Host processor model issuing single I/O read and write cycles.
// Assumes: The bank answers exactly one cycle after the request edge.
// Notes: Idle request fields show inverted values so stale data never looks valid.
`timescale 1ns/1ps
module hra_host_model (
    input wire logic clk_sys_i,
    input hra_pkg::hra_io_rsp_t io_rsp_i,
    output hra_pkg::hra_io_req_t io_req_o
);
    import hra_pkg::*;
    initial begin
        io_req_o = '0;
    end
    // Callers skip reserved writes but may issue narrow config address writes
    task automatic cyc(input logic wr, input logic [15:0] addr, input logic [3:0] be, input logic [31:0] wd,
                       output logic [31:0] rd, output logic ack);
        @(posedge clk_sys_i);
        #1;
        io_req_o = '{valid: 1'b1, wr: wr, addr: addr, be: be, wdata: wd};
        @(posedge clk_sys_i);
        #1;
        ack = io_rsp_i.ack;
        rd = io_rsp_i.rdata;
        io_req_o = '{valid: 1'b0, wr: ~wr, addr: ~addr, be: ~be, wdata: ~wd};
    endtask
endmodule
